// ---- hdl/drive_health_pkg.sv ----
`default_nettype none
package drive_health_pkg;
    // fieldbus addresses of the readable monitoring values
    localparam logic [15:0] ADDR_TEMP_WARN = 16'h100c;
    localparam logic [15:0] ADDR_TEMP_MAX  = 16'h100e;
    localparam logic [15:0] ADDR_TEMP_ACT  = 16'h1c20;
    localparam logic [15:0] ADDR_OVERLOAD  = 16'h1c32;
    localparam logic [15:0] ADDR_MEAN_LOAD = 16'h1c34;

    // timing
    localparam int CLK_HZ            = 100_000_000;
    localparam int TEMP_HOLD_S       = 5;
    localparam int TEMP_HOLD_CYCLES  = TEMP_HOLD_S * CLK_HZ;
    localparam int FLASH_HALF_MS     = 250;
    localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * (CLK_HZ / 1000);
    localparam int PAUSE_TICKS       = 4;

    // load integration
    localparam int                 OV_SHIFT      = 6;
    localparam int                 MEAN_SHIFT    = 12;
    localparam logic signed [15:0] I2T_LIMIT_PCT = 16'sh0064;

    // latched minor error word layout
    localparam int          BIT_TEMP_HIGH = 1;
    localparam int          BIT_MOTOR_I2T = 5;
    localparam logic [15:0] LATCH_RESET   = 16'h0000;

    typedef enum logic [2:0] {
        FB_BOOT       = 3'b000,
        FB_READY      = 3'b001,
        FB_NOCONN     = 3'b010,
        FB_IPERASE    = 3'b011,
        FB_IPCONFLICT = 3'b100,
        FB_AWAITADDR  = 3'b101,
        FB_DEFAULTIP  = 3'b110
    } fb_state_type;

    typedef enum logic {
        SEQ_FLASH = 1'b0,
        SEQ_PAUSE = 1'b1
    } seq_type;

    typedef enum logic [1:0] {
        LAMP_OFF  = 2'b00,
        LAMP_ON   = 2'b01,
        LAMP_SLOW = 2'b10,
        LAMP_FAST = 2'b11
    } lamp_type;
endpackage
`default_nettype wire

// ---- hdl/drive_health_monitor_indicator.sv ----
// What this block does
// R1 - The power stage temperature is sampled continuously and read back as a signed word at address 7200.
// R2 - A lowest-class error is raised whenever the temperature is above the stored warning threshold.
// R3 - The severe error is raised only after the temperature stays above the maximum for more than five seconds.
// R4 - Load is integrated and, while the overload level is above its limit, current is held to nominal.
// R5 - The nominal-current restriction is dropped as soon as the overload level is back under the limit.
// R6 - Motor overload and mean load are read back as signed percentages at addresses 7218 and 7220.
// R7 - A green and a red lamp together show the operating state and any error.
// R8 - The lamp pair has nine distinct patterns for the state groups, missing firmware and internal error.
// R9 - The fieldbus lamp flashes continuously while booting and is steadily lit when ready.
// R10 - The fieldbus lamp flashes twice per cycle when there is no network connection.
// R11 - The fieldbus lamp flashes three times per cycle when erased IP settings left no valid address.
// R12 - The fieldbus lamp flashes four times per cycle after an address conflict.
// R13 - The fieldbus lamp flashes five times per cycle while waiting for an address server.
// R14 - The fieldbus lamp flashes six times per cycle while running on the default address.
// R15 - Each blink cycle is the flash count followed by a dark pause, with an adjustable flash length and a fixed pause of four flash ticks.
// R16 - The latched minor error word sets bit 1 on high stage temperature and bit 5 on motor overload.
`default_nettype none
module drive_health_monitor_indicator
    import drive_health_pkg::*;
#(
    parameter int HOLD_CYCLES  = TEMP_HOLD_CYCLES,
    parameter int FLASH_CYCLES = FLASH_HALF_CYCLES
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst,
    // fieldbus read port
    input  wire logic               rdEn,
    input  wire logic [15:0]        rdAddr,
    output logic      [15:0]        rdData_r,
    output logic                    rdAck_r,
    output logic                    rdMiss_r,
    // measurements and persistent limits
    input  wire logic               tempValid,
    input  wire logic signed [15:0] tempSample,
    input  wire logic signed [15:0] warnLimit,
    input  wire logic signed [15:0] maxLimit,
    input  wire logic               loadValid,
    input  wire logic signed [15:0] loadSample,
    // error handling
    input  wire logic               faultReset,
    output logic                    tempWarn_r,
    output logic                    tempFault_r,
    output logic                    currentLimitNominal_r,
    output logic      [15:0]        latchedMinorErrorWord_r,
    // lamps
    input  wire logic [3:0]         opState,
    input  wire logic               firmwareMissing,
    input  wire logic               internalError,
    input  wire fb_state_type       fbState,
    output logic                    greenLed_r,
    output logic                    redLed_r,
    output logic                    fbLed_r
);

    // leaky integrator step, shared by both load filters
    function automatic logic signed [23:0] leak(input logic signed [23:0] acc,
                                                input logic signed [15:0] smp,
                                                input int                 sh);
        // size cast keeps the sum signed so the leak term shifts arithmetically
        leak = acc + 24'(smp) - (acc >>> sh);
    endfunction

    // flashes per blink cycle, zero for the non-counted modes
    function automatic logic [2:0] flashCount(input fb_state_type st);
        unique case (st)
            // R10 - two flashes
            FB_NOCONN:     flashCount = 3'h2;
            // R11 - three flashes
            FB_IPERASE:    flashCount = 3'h3;
            // R12 - four flashes
            FB_IPCONFLICT: flashCount = 3'h4;
            // R13 - five flashes
            FB_AWAITADDR:  flashCount = 3'h5;
            // R14 - six flashes
            FB_DEFAULTIP:  flashCount = 3'h6;
            default:       flashCount = 3'h0;
        endcase
    endfunction

    // lamp mode to lamp level
    function automatic logic lampLevel(input lamp_type m, input logic slow, input logic fast);
        unique case (m)
            LAMP_OFF:  lampLevel = 1'b0;
            LAMP_ON:   lampLevel = 1'b1;
            LAMP_SLOW: lampLevel = slow;
            LAMP_FAST: lampLevel = fast;
        endcase
    endfunction

    logic signed [15:0] tempAct_r;
    logic        [31:0] overCnt_r;
    logic signed [23:0] ovAcc_r;
    logic signed [23:0] meanAcc_r;
    logic        [31:0] flashDiv_r;
    logic        [1:0]  blinkDiv_r;
    seq_type            seq_r;
    logic        [3:0]  step_r;
    fb_state_type       fbPrev_r;

    // R1 - temperature capture
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tempAct_r <= 16'sh0000;
        end else if (tempValid) begin
            tempAct_r <= tempSample;
        end
    end

    // temperature comparisons
    wire logic tempAboveWarn = tempAct_r > warnLimit;
    wire logic tempAboveMax  = tempAct_r > maxLimit;
    wire logic holdDone      = overCnt_r >= 32'(HOLD_CYCLES);

    // R3 - persistence counter
    // counter saturates so a long overheat cannot wrap back to zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            overCnt_r <= 32'h0000_0000;
        end else if (!tempAboveMax) begin
            overCnt_r <= 32'h0000_0000;
        end else if (!holdDone) begin
            overCnt_r <= overCnt_r + 32'h0000_0001;
        end
    end

    // R2 - warning level and severe fault
    // the severe fault stays until a fault reset once the stage has cooled
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tempWarn_r  <= 1'b0;
            tempFault_r <= 1'b0;
        end else begin
            tempWarn_r  <= tempAboveWarn;
            tempFault_r <= (tempAboveMax && holdDone) || (tempFault_r && !faultReset);
        end
    end

    // R4 - load integration, fast for overload and slow for mean load
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ovAcc_r   <= 24'sh000000;
            meanAcc_r <= 24'sh000000;
        end else if (loadValid) begin
            ovAcc_r   <= leak(ovAcc_r, loadSample, OV_SHIFT);
            meanAcc_r <= leak(meanAcc_r, loadSample, MEAN_SHIFT);
        end
    end

    // R6 - filtered percentages
    wire logic signed [23:0] ovWide   = ovAcc_r >>> OV_SHIFT;
    wire logic signed [23:0] meanWide = meanAcc_r >>> MEAN_SHIFT;
    wire logic signed [15:0] overloadLvl = ovWide[15:0];
    wire logic signed [15:0] meanLoad    = meanWide[15:0];
    wire logic               i2tOver     = overloadLvl > I2T_LIMIT_PCT;

    // R5 - restriction follows the overload level both ways
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            currentLimitNominal_r <= 1'b0;
        end else begin
            currentLimitNominal_r <= i2tOver;
        end
    end

    // R16 - latched word set terms; a set in the reset cycle wins
    wire logic [15:0] latchSet = (16'(tempAboveWarn) << BIT_TEMP_HIGH) | (16'(i2tOver) << BIT_MOTOR_I2T);
    wire logic [15:0] latchKeep = faultReset ? LATCH_RESET : latchedMinorErrorWord_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            latchedMinorErrorWord_r <= LATCH_RESET;
        end else begin
            latchedMinorErrorWord_r <= latchKeep | latchSet;
        end
    end

    // R6 - address decode of the read port
    wire logic hitTemp = rdAddr == ADDR_TEMP_ACT;
    wire logic hitWarn = rdAddr == ADDR_TEMP_WARN;
    wire logic hitMax  = rdAddr == ADDR_TEMP_MAX;
    wire logic hitOv   = rdAddr == ADDR_OVERLOAD;
    wire logic hitMean = rdAddr == ADDR_MEAN_LOAD;
    wire logic hitAny  = hitTemp | hitWarn | hitMax | hitOv | hitMean;
    wire logic [15:0] rdMux = ({16{hitTemp}} & tempAct_r) | ({16{hitWarn}} & warnLimit)
                            | ({16{hitMax}} & maxLimit) | ({16{hitOv}} & overloadLvl)
                            | ({16{hitMean}} & meanLoad);

    // R1 - read answer one cycle after the request; unmapped reads return zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdData_r <= 16'h0000;
            rdAck_r  <= 1'b0;
            rdMiss_r <= 1'b0;
        end else begin
            rdData_r <= rdEn ? rdMux : 16'h0000;
            rdAck_r  <= rdEn;
            rdMiss_r <= rdEn && !hitAny;
        end
    end

    // R15 - flash timebase, one tick per half flash period
    wire logic flashTick = flashDiv_r == 32'(FLASH_CYCLES - 1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flashDiv_r <= 32'h0000_0000;
            blinkDiv_r <= 2'h0;
        end else begin
            flashDiv_r <= flashTick ? 32'h0000_0000 : flashDiv_r + 32'h0000_0001;
            blinkDiv_r <= flashTick ? blinkDiv_r + 2'h1 : blinkDiv_r;
        end
    end

    // R8 - pattern select, error conditions take priority over the state
    lamp_type greenMode;
    lamp_type redMode;

    always_comb begin
        greenMode = LAMP_OFF;
        redMode   = LAMP_OFF;
        if (internalError) begin
            greenMode = LAMP_ON;
            redMode   = LAMP_ON;
        end else if (firmwareMissing) begin
            redMode   = LAMP_FAST;
        end else begin
            unique case (opState)
                4'h1, 4'h2: begin
                    greenMode = LAMP_SLOW;
                    redMode   = LAMP_SLOW;
                end
                4'h3:       greenMode = LAMP_SLOW;
                4'h4, 4'h5: greenMode = LAMP_FAST;
                4'h6:       greenMode = LAMP_ON;
                4'h7, 4'h8: begin
                    greenMode = LAMP_ON;
                    redMode   = LAMP_FAST;
                end
                4'h9:       redMode   = LAMP_SLOW;
                default:    redMode   = LAMP_ON;
            endcase
        end
    end

    // R7 - both state lamps
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            greenLed_r <= 1'b0;
            redLed_r   <= 1'b0;
        end else begin
            greenLed_r <= lampLevel(greenMode, blinkDiv_r[1], blinkDiv_r[0]);
            redLed_r   <= lampLevel(redMode, blinkDiv_r[1], blinkDiv_r[0]);
        end
    end

    // fieldbus blink sequencer terms
    wire logic [2:0] nFlash   = flashCount(fbState);
    wire logic [3:0] lastStep = {nFlash, 1'b0} - 4'h1;
    wire logic       modeChg  = fbState != fbPrev_r;

    // R15 - flash count then dark pause; a mode change restarts the cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seq_r    <= SEQ_FLASH;
            step_r   <= 4'h0;
            fbPrev_r <= FB_BOOT;
        end else begin
            fbPrev_r <= fbState;
            if (modeChg) begin
                seq_r  <= SEQ_FLASH;
                step_r <= 4'h0;
            end else if (flashTick) begin
                unique case (seq_r)
                    SEQ_FLASH: begin
                        step_r <= (step_r == lastStep) ? 4'h0 : step_r + 4'h1;
                        seq_r  <= (step_r == lastStep && nFlash != 3'h0) ? SEQ_PAUSE : SEQ_FLASH;
                    end
                    SEQ_PAUSE: begin
                        step_r <= (step_r == 4'(PAUSE_TICKS - 1)) ? 4'h0 : step_r + 4'h1;
                        seq_r  <= (step_r == 4'(PAUSE_TICKS - 1)) ? SEQ_FLASH : SEQ_PAUSE;
                    end
                endcase
            end
        end
    end

    // R9 - continuous flash while booting, steady when ready
    // R10 - R14 counted flashes lit on even steps, dark in the pause
    wire logic fbLedNxt = (fbState == FB_READY) ? 1'b1
                        : (nFlash == 3'h0)      ? blinkDiv_r[0]
                        : (seq_r == SEQ_FLASH)  ? !step_r[0] && !modeChg
                        : 1'b0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fbLed_r <= 1'b0;
        end else begin
            fbLed_r <= fbLedNxt;
        end
    end

    // checks
    readAck_a: assert property (@(posedge sys_clk) disable iff (rst)   // R1
        rdEn |=> rdAck_r) else $error("read not answered");
    readTemp_a: assert property (@(posedge sys_clk) disable iff (rst)   // R1
        rdEn && rdAddr == ADDR_TEMP_ACT |=> rdData_r == $past(tempAct_r)) else $error("bad temperature read");
    warnRaise_a: assert property (@(posedge sys_clk) disable iff (rst)   // R2
        tempAct_r > warnLimit |=> tempWarn_r) else $error("warning not raised");
    faultHold_a: assert property (@(posedge sys_clk) disable iff (rst)   // R3
        $rose(tempFault_r) |-> $past(overCnt_r) >= 32'(HOLD_CYCLES) && $past(tempAboveMax))
        else $error("fault raised too early");
    limitApply_a: assert property (@(posedge sys_clk) disable iff (rst)   // R4
        i2tOver |=> currentLimitNominal_r) else $error("current not limited");
    limitRelease_a: assert property (@(posedge sys_clk) disable iff (rst)   // R5
        !i2tOver |=> !currentLimitNominal_r) else $error("limit not released");
    readLoad_a: assert property (@(posedge sys_clk) disable iff (rst)   // R6
        rdEn && rdAddr == ADDR_MEAN_LOAD |=> rdData_r == $past(meanLoad)) else $error("bad mean load read");
    latchTemp_a: assert property (@(posedge sys_clk) disable iff (rst)   // R16
        tempAboveWarn |=> latchedMinorErrorWord_r[BIT_TEMP_HIGH])
        else $error("temperature bit not latched");
    latchI2t_a: assert property (@(posedge sys_clk) disable iff (rst)   // R16
        i2tOver |=> latchedMinorErrorWord_r[BIT_MOTOR_I2T]) else $error("overload bit not latched");
    lampInternal_a: assert property (@(posedge sys_clk) disable iff (rst)   // R8
        internalError |=> greenLed_r && redLed_r) else $error("internal error pattern wrong");
    fbReady_a: assert property (@(posedge sys_clk) disable iff (rst)   // R9
        fbState == FB_READY |=> fbLed_r) else $error("ready lamp not steady");
    fbPause_a: assert property (@(posedge sys_clk) disable iff (rst)   // R15
        seq_r == SEQ_PAUSE && !modeChg && fbState != FB_READY |=> !fbLed_r) else $error("lamp lit in pause");
    readOverload_a: assert property (@(posedge sys_clk) disable iff (rst)   // R6
        rdEn && rdAddr == ADDR_OVERLOAD |=> !rdMiss_r && rdData_r == $past(overloadLvl)) else $error("bad overload read");
    readUnmapped_a: assert property (@(posedge sys_clk) disable iff (rst)   // R1
        rdEn && !hitAny |=> rdMiss_r && rdData_r == 16'h0000) else $error("unmapped read not flagged");
    warnClear_a: assert property (@(posedge sys_clk) disable iff (rst)   // R2
        !tempAboveWarn |=> !tempWarn_r) else $error("warning without overheat");
    faultEarly_a: assert property (@(posedge sys_clk) disable iff (rst)   // R3
        tempAboveMax && !holdDone && !tempFault_r |=> !tempFault_r) else $error("fault before hold time");
    lampFirmware_a: assert property (@(posedge sys_clk) disable iff (rst)   // R8
        !internalError && firmwareMissing |=> !greenLed_r) else $error("firmware pattern wrong");

endmodule // drive_health_monitor_indicator
`default_nettype wire

// ---- testbench/fieldbus_master_model.sv ----
`default_nettype none
// fieldbus master: one word read at a time over the monitor's read port
module fieldbus_master_model (
    // clock
    input  wire logic        sys_clk,
    // read port
    output logic             rdEn,
    output logic [15:0]      rdAddr,
    input  wire logic [15:0] rdData_r,
    input  wire logic        rdAck_r,
    input  wire logic        rdMiss_r
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rdEn   = 1'b0;
        rdAddr = 16'h0000;
    end
    // request driven for one cycle, answer sampled just after the edge that takes it; ok low means no answer
    task automatic read_word(input logic [15:0] a, output logic [15:0] d, output logic m, output logic ok);
        ok = 1'b0;
        d  = 16'h0000;
        m  = 1'b0;
        @(posedge sys_clk);
        #1 rdEn = 1'b1;
        rdAddr = a;
        @(posedge sys_clk);
        // released address shows the inverse so a stale value cannot pass
        #1 rdEn = 1'b0;
        rdAddr = ~a;
        // answer looked at while it stands, settled after the edge
        repeat (3) begin
            if (rdAck_r === 1'b1 && ok === 1'b0) begin
                d  = rdData_r;
                m  = rdMiss_r;
                ok = 1'b1;
            end
            @(posedge sys_clk);
            #1;
        end
    endtask
endmodule // fieldbus_master_model
`default_nettype wire

// ---- testbench/drive_health_monitor_indicator_tb.sv ----
`default_nettype none
module drive_health_monitor_indicator_tb;
    import drive_health_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HOLD = 20;
    localparam int FLASH = 4;
    typedef struct packed {logic [15:0] a; logic [15:0] d; logic m;} rdRow_type;
    typedef struct packed {logic [3:0] st; logic fw; logic ie; lamp_type g; lamp_type r;} lampRow_type;
    logic sys_clk = 1'b0, rst = 1'b1, rdEn, rdAck_r, rdMiss_r, tempValid = 1'b0, loadValid = 1'b0;
    logic [15:0] rdAddr, rdData_r, latchedMinorErrorWord_r;
    logic signed [15:0] tempSample = 16'sh002d, warnLimit = 16'sh003c, maxLimit = 16'sh0050, loadSample = 16'sh0000;
    logic faultReset = 1'b0, tempWarn_r, tempFault_r, currentLimitNominal_r;
    logic [3:0] opState = 4'h6;
    logic firmwareMissing = 1'b0, internalError = 1'b0, greenLed_r, redLed_r, fbLed_r;
    fb_state_type fbState = FB_READY;
    int errTotal = 0, checks = 0, cycles = 0, acc = 0, lvl = 0, on_g, on_r, tr_g, tr_r, rises;
    logic [15:0] d;
    logic m, ok, pg, pr, pf;
    lamp_type cg, cr;
    rdRow_type rdRows [6];
    lampRow_type lampRows [12];
    always #5 sys_clk = ~sys_clk;
    drive_health_monitor_indicator #(.HOLD_CYCLES(HOLD), .FLASH_CYCLES(FLASH)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .rdEn(rdEn), .rdAddr(rdAddr), .rdData_r(rdData_r), .rdAck_r(rdAck_r),
        .rdMiss_r(rdMiss_r), .tempValid(tempValid), .tempSample(tempSample), .warnLimit(warnLimit),
        .maxLimit(maxLimit), .loadValid(loadValid), .loadSample(loadSample), .faultReset(faultReset),
        .tempWarn_r(tempWarn_r), .tempFault_r(tempFault_r), .currentLimitNominal_r(currentLimitNominal_r),
        .latchedMinorErrorWord_r(latchedMinorErrorWord_r), .opState(opState), .firmwareMissing(firmwareMissing),
        .internalError(internalError), .fbState(fbState), .greenLed_r(greenLed_r), .redLed_r(redLed_r),
        .fbLed_r(fbLed_r));
    fieldbus_master_model u_master (.sys_clk(sys_clk), .rdEn(rdEn), .rdAddr(rdAddr), .rdData_r(rdData_r),
        .rdAck_r(rdAck_r), .rdMiss_r(rdMiss_r));
    // compare and count; case inequality so unknowns never match
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errTotal++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic temp_in(input logic signed [15:0] v);
        tempValid = 1'b1;
        tempSample = v;
        cyc(1);
        tempValid = 1'b0;
    endtask
    // one load sample, mirrored in the fast filter model
    task automatic load_in(input logic signed [15:0] v);
        loadValid = 1'b1;
        loadSample = v;
        acc = acc + v - (acc >>> 6);
        lvl = acc >>> 6;
        cyc(1);
        loadValid = 1'b0;
        cyc(2);
    endtask
    function automatic lamp_type kind(input int on, input int tr);
        if (on == 0) return LAMP_OFF;
        if (on == 32) return LAMP_ON;
        return (tr >= 6) ? LAMP_FAST : LAMP_SLOW;
    endfunction
    task automatic wrap_up();
        if (errTotal == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard well above the expected run length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errTotal++;
            wrap_up();
        end
    end
    initial begin
        rdRows = '{'{ADDR_TEMP_WARN, 16'h003c, 1'b0}, '{ADDR_TEMP_MAX, 16'h0050, 1'b0},
            '{ADDR_TEMP_ACT, 16'h002d, 1'b0}, '{ADDR_OVERLOAD, 16'h0000, 1'b0}, '{ADDR_MEAN_LOAD, 16'h0000, 1'b0},
            '{16'h1c22, 16'h0000, 1'b1}};
        lampRows = '{'{4'h1, 1'b0, 1'b0, LAMP_SLOW, LAMP_SLOW}, '{4'h2, 1'b0, 1'b0, LAMP_SLOW, LAMP_SLOW},
            '{4'h3, 1'b0, 1'b0, LAMP_SLOW, LAMP_OFF}, '{4'h4, 1'b0, 1'b0, LAMP_FAST, LAMP_OFF},
            '{4'h5, 1'b0, 1'b0, LAMP_FAST, LAMP_OFF}, '{4'h6, 1'b0, 1'b0, LAMP_ON, LAMP_OFF},
            '{4'h7, 1'b0, 1'b0, LAMP_ON, LAMP_FAST}, '{4'h8, 1'b0, 1'b0, LAMP_ON, LAMP_FAST},
            '{4'h9, 1'b0, 1'b0, LAMP_OFF, LAMP_SLOW}, '{4'h6, 1'b1, 1'b0, LAMP_OFF, LAMP_FAST},
            '{4'h6, 1'b1, 1'b1, LAMP_ON, LAMP_ON}, '{4'h0, 1'b0, 1'b0, LAMP_OFF, LAMP_ON}};
        cyc(4);
        chk({tempFault_r, currentLimitNominal_r, fbLed_r, greenLed_r, rdAck_r}, 16'h0000, "reset outputs");
        chk(latchedMinorErrorWord_r, LATCH_RESET, "reset latch");
        cyc(4);
        rst = 1'b0;
        temp_in(16'sh002d);
        cyc(2);
        // read table: values, limits and the unmapped miss
        // read map
        foreach (rdRows[i]) begin
            u_master.read_word(rdRows[i].a, d, m, ok);
            chk({ok, m}, {14'h0, 1'b1, rdRows[i].m}, "read ack/miss");
            chk(d, rdRows[i].d, "read data");
        end
        // equal to the warning threshold is not above it
        temp_in(16'sh003c);
        cyc(3);
        chk(16'(tempWarn_r), 16'h0000, "warn at limit");
        temp_in(16'sh0046);
        cyc(3);
        chk(16'(tempWarn_r), 16'h0001, "warn above");
        chk(latchedMinorErrorWord_r & 16'h0002, 16'h0002, "latch bit1");
        // at max for long, then above max with an interruption
        temp_in(16'sh0050);
        cyc(30);
        chk(16'(tempFault_r), 16'h0000, "fault at max");
        temp_in(16'sh005a);
        cyc(HOLD - 10);
        temp_in(16'sh0046);
        temp_in(16'sh005a);
        cyc(HOLD - 5);
        chk(16'(tempFault_r), 16'h0000, "fault early");
        cyc(10);
        chk(16'(tempFault_r), 16'h0001, "fault raised");
        temp_in(16'sh0046);
        cyc(5);
        chk(16'(tempFault_r), 16'h0001, "fault sticky");
        faultReset = 1'b1;
        cyc(1);
        faultReset = 1'b0;
        cyc(2);
        chk({tempFault_r, latchedMinorErrorWord_r[1]}, 16'h0001, "reset while warm");
        temp_in(16'sh002d);
        cyc(2);
        faultReset = 1'b1;
        cyc(1);
        faultReset = 1'b0;
        cyc(2);
        chk(latchedMinorErrorWord_r, 16'h0000, "latch cleared");
        // load rises past the limit, then decays below it
        // overload
        repeat (70) begin
            load_in(16'sh00c8);
            chk(16'(currentLimitNominal_r), 16'(lvl > 100), "limit rising");
        end
        u_master.read_word(ADDR_OVERLOAD, d, m, ok);
        chk(d, 16'(lvl), "overload level");
        u_master.read_word(ADDR_MEAN_LOAD, d, m, ok);
        chk(16'(signed'(d) > 0 && signed'(d) <= lvl), 16'h0001, "mean load");
        chk(latchedMinorErrorWord_r & 16'h0020, 16'h0020, "latch bit5");
        repeat (70) begin
            load_in(16'sh0000);
            chk(16'(currentLimitNominal_r), 16'(lvl > 100), "limit falling");
        end
        // operating lamps: classify 32 samples of each pattern
        // lamp pairs
        foreach (lampRows[i]) begin
            opState = lampRows[i].st;
            firmwareMissing = lampRows[i].fw;
            internalError = lampRows[i].ie;
            cyc(2);
            {on_g, on_r, tr_g, tr_r, pg, pr} = '0;
            repeat (32) begin
                cyc(1);
                on_g += greenLed_r;
                on_r += redLed_r;
                tr_g += (greenLed_r != pg);
                tr_r += (redLed_r != pr);
                pg = greenLed_r;
                pr = redLed_r;
            end
            cg = kind(on_g, tr_g);
            cr = kind(on_r, tr_r);
            chk({cg, cr}, {lampRows[i].g, lampRows[i].r}, "lamp pair");
        end
        fbState = FB_READY;
        cyc(3);
        on_g = 0;
        repeat (16) begin
            cyc(1);
            on_g += fbLed_r;
        end
        chk(16'(on_g), 16'd16, "fb ready steady");
        fbState = FB_BOOT;
        {rises, pf} = '0;
        repeat (32) begin
            cyc(1);
            rises += (fbLed_r && !pf);
            pf = fbLed_r;
        end
        chk(16'(rises >= 3), 16'h0001, "fb boot flashing");
        // counted modes: flashes in one cycle, then the dark pause
        // counted flashes
        for (int n = 2; n <= 6; n++) begin
            fbState = fb_state_type'(3'(n));
            {rises, pf} = '0;
            repeat ((2 * n + 2) * FLASH + 4) begin
                cyc(1);
                rises += (fbLed_r && !pf);
                pf = fbLed_r;
            end
            chk(16'(rises), 16'(n), "fb flash count");
        end
        wrap_up();
    end
endmodule // drive_health_monitor_indicator_tb
`default_nettype wire
